// >>> core/eiap_device.sv
// Device end: indirect access port to the configuration EEPROM page
//
// Operation
// RL1: Address register selects next indirect location
// RL2: Data register write programs addressed byte
// RL3: Each programming cycle lasts twenty milliseconds
// RL4: Indirect write leaves live register unchanged
// RL5: EEPROM copied to live registers only at reset
// RL6: Data register read returns EEPROM byte only
// RL7: Data reads advance the indirect address
// RL8: Part release byte readable only indirectly
// RL9: Wafer and die identifiers readable only indirectly
// RL10: Page holds read-only identification bytes
// RL11: Host avoids user byte write during acquisition
// RL12: Host limits user byte writes to hundred
// RL13: General-call reset acts as reset pin
// RL14: Silicon revision readable as live register
// RL15: Host waits ready, loads program before shutter
// RL16: Host waits programming time before next access
module eiap_device #(
	parameter int unsigned PROG_CYCLES = eiap_pkg::PROG_CYCLES,
	parameter logic [7:0]  SILICON_REV = 8'h3c, // Value is arbitrary
	parameter logic [7:0]  CUSTOMER_IDENTIFIER = eiap_pkg::CUSTOMER_RESET,
	parameter logic [15:0] WAFER_IDENT = 16'h2d71, // Value is arbitrary
	parameter logic [15:0] DIE_ID      = 16'h0b9e, // Value is arbitrary
	parameter logic [7:0]  PART_TYPE   = 8'h5a, // Value is arbitrary
	parameter logic [7:0]  PART_REL    = 8'h21 // Value is arbitrary
) (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic nv_init,
	eiap_if.dev       link
);

	localparam int unsigned PW = $clog2(PROG_CYCLES + 1);

	// ------------------------------------------------------------
	// Factory image of the page
	// ------------------------------------------------------------
	function automatic logic [7:0] nv_factory(input logic [7:0] a);
		logic [7:0] v;
		v = eiap_pkg::READ_ZERO;
		unique case (a)
			eiap_pkg::REG_USER_NV:   v = eiap_pkg::USER_NV_RESET;
			eiap_pkg::REG_CUSTOMER:  v = CUSTOMER_IDENTIFIER; // RL10
			eiap_pkg::REG_WAFER_HI:  v = WAFER_IDENT[15:8]; // RL10
			eiap_pkg::REG_WAFER_LO:  v = WAFER_IDENT[7:0]; // RL10
			eiap_pkg::REG_DIE_HI:    v = DIE_ID[15:8]; // RL10
			eiap_pkg::REG_DIE_LO:    v = DIE_ID[7:0]; // RL10
			eiap_pkg::REG_PART_TYPE: v = PART_TYPE; // RL10
			eiap_pkg::REG_PART_REL:  v = PART_REL; // RL10
			default:                 v = eiap_pkg::READ_ZERO;
		endcase
		return v;
	endfunction

	logic                          gc_rst;
	logic                          next_gc_rst;
	logic                          sys_rst;
	logic                          take_gc;
	logic                          take_wr;
	logic                          take_rd;
	logic                          busy;
	logic                          prog_start;
	logic [eiap_pkg::NV_IDX_W-1:0] ptr_idx;
	logic [7:0]                    nv_mem [eiap_pkg::NV_DEPTH];
	logic [7:0]                    next_nv_mem [eiap_pkg::NV_DEPTH];
	logic [PW-1:0]                 prog_cnt;
	logic [PW-1:0]                 next_prog_cnt;
	logic [7:0]                    nv_addr;
	logic [7:0]                    next_nv_addr;
	logic [7:0]                    live_user;
	logic [7:0]                    next_live_user;
	logic [7:0]                    live_customer;
	logic [7:0]                    next_live_customer;
	logic [7:0]                    live_part_type;
	logic [7:0]                    next_live_part_type;
	logic                          ack;
	logic                          next_ack;
	logic [7:0]                    rdata;
	logic [7:0]                    next_rdata;
	logic                          ready;
	logic                          next_ready;

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	assign take_gc    = link.req && link.gcall && (link.wdata == eiap_pkg::GCALL_RESET);
	assign take_wr    = link.req && !link.gcall && link.wr && !sys_rst;
	assign take_rd    = link.req && !link.gcall && !link.wr && !sys_rst;
	assign busy       = (prog_cnt != '0);
	assign prog_start = take_wr && (link.addr == eiap_pkg::REG_NV_DATA) && !busy; // RL2
	assign ptr_idx    = nv_addr[eiap_pkg::NV_IDX_W-1:0];

	// ------------------------------------------------------------
	// Reset sequencing
	// ------------------------------------------------------------
	// General call gives a one-cycle internal reset, same path as the pin
	assign sys_rst = rst || gc_rst; // RL13

	always_comb
	begin
		next_gc_rst = take_gc; // RL13
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			gc_rst <= 1'b0;
		else
			gc_rst <= next_gc_rst;
	end

	// ------------------------------------------------------------
	// Nonvolatile array, kept through every reset
	// ------------------------------------------------------------
	always_comb
	begin
		next_nv_mem = nv_mem;
		if (nv_init)
		begin
			for (int i = 0; i < eiap_pkg::NV_DEPTH; i++)
			begin
				next_nv_mem[i] = nv_factory(eiap_pkg::NV_PAGE_BASE | 8'(i));
			end
		end
		else if (prog_start && eiap_pkg::nv_in_page(nv_addr)
			&& eiap_pkg::nv_writable(nv_addr))
		begin
			next_nv_mem[ptr_idx] = link.wdata; // RL2
		end
	end

	always_ff @(posedge clock)
	begin
		nv_mem <= next_nv_mem;
	end

	// ------------------------------------------------------------
	// Programming timer; further data writes ignored while busy
	// ------------------------------------------------------------
	always_comb
	begin
		next_prog_cnt = prog_cnt;
		if (prog_start)
			next_prog_cnt = PW'(PROG_CYCLES); // RL3
		else if (busy)
			next_prog_cnt = prog_cnt - PW'(1); // RL3
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			prog_cnt <= '0;
		else
			prog_cnt <= next_prog_cnt;
	end

	// ------------------------------------------------------------
	// Indirect address pointer
	// ------------------------------------------------------------
	always_comb
	begin
		next_nv_addr = nv_addr;
		if (take_wr && (link.addr == eiap_pkg::REG_NV_ADDR))
			next_nv_addr = link.wdata; // RL1
		else if (take_rd && (link.addr == eiap_pkg::REG_NV_DATA))
			next_nv_addr = nv_addr + 8'h01; // RL7
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			nv_addr <= eiap_pkg::NV_ADDR_RESET;
		else
			nv_addr <= next_nv_addr;
	end

	// ------------------------------------------------------------
	// Live control registers, loaded from the array during reset
	// ------------------------------------------------------------
	always_comb
	begin
		next_live_user      = live_user; // RL4
		next_live_customer  = live_customer;
		next_live_part_type = live_part_type;
		if (sys_rst)
		begin
			next_live_user      = nv_mem[eiap_pkg::REG_USER_NV[eiap_pkg::NV_IDX_W-1:0]]; // RL5
			next_live_customer  = nv_mem[eiap_pkg::REG_CUSTOMER[eiap_pkg::NV_IDX_W-1:0]]; // RL5
			next_live_part_type = nv_mem[eiap_pkg::REG_PART_TYPE[eiap_pkg::NV_IDX_W-1:0]]; // RL5
		end
		else if (take_wr && (link.addr == eiap_pkg::REG_USER_NV))
		begin
			next_live_user = link.wdata;
		end
	end

	always_ff @(posedge clock)
	begin
		live_user      <= next_live_user;
		live_customer  <= next_live_customer;
		live_part_type <= next_live_part_type;
	end

	// ------------------------------------------------------------
	// Answer path
	// ------------------------------------------------------------
	always_comb
	begin
		next_ack   = !sys_rst && (take_wr || take_rd || take_gc);
		next_rdata = eiap_pkg::READ_ZERO;
		next_ready = !sys_rst && !busy;
		if (take_rd)
		begin
			unique case (link.addr)
				eiap_pkg::REG_SIL_REV:   next_rdata = SILICON_REV; // RL14
				eiap_pkg::REG_NV_ADDR:   next_rdata = nv_addr;
				eiap_pkg::REG_NV_DATA:
				begin
					if (eiap_pkg::nv_in_page(nv_addr))
						next_rdata = nv_mem[ptr_idx]; // RL6 RL8 RL9
				end
				eiap_pkg::REG_USER_NV:   next_rdata = live_user;
				eiap_pkg::REG_CUSTOMER:  next_rdata = live_customer;
				eiap_pkg::REG_PART_TYPE: next_rdata = live_part_type;
				// Identifier and release bytes have no live copy
				default:                 next_rdata = eiap_pkg::READ_ZERO; // RL8 RL9
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ack   <= 1'b0;
			rdata <= eiap_pkg::READ_ZERO;
			ready <= 1'b0;
		end
		else
		begin
			ack   <= next_ack;
			rdata <= next_rdata;
			ready <= next_ready;
		end
	end

	assign link.ack   = ack;
	assign link.rdata = rdata;
	assign link.ready = ready;

endmodule

// >>> core/eiap_host.sv
// Host end: issues register accesses and keeps the access timing
module eiap_host #(
	parameter int unsigned PROG_CYCLES       = eiap_pkg::PROG_CYCLES,
	parameter int unsigned RESET_WAIT_CYCLES = eiap_pkg::RESET_WAIT_CYCLES,
	parameter int unsigned USER_WRITE_LIMIT  = eiap_pkg::USER_WRITE_LIMIT
) (
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire logic                 cmd_valid,
	output logic                      cmd_ready,
	input  wire eiap_pkg::eiap_kind_e cmd_kind,
	input  wire logic [7:0]           cmd_addr,
	input  wire logic [7:0]           cmd_data,
	input  wire logic                 acq_active,
	input  wire logic                 seq_loaded,
	output logic                      rsp_valid,
	output logic [7:0]                rsp_data,
	output logic                      user_limit_hit,
	eiap_if.host                      link
);

	localparam int unsigned PW = $clog2(PROG_CYCLES + 1);
	localparam int unsigned GW = $clog2(RESET_WAIT_CYCLES + 1);
	localparam int unsigned UW = $clog2(USER_WRITE_LIMIT + 1);

	typedef enum logic [1:0] {
		H_IDLE = 2'b01,
		H_WAIT = 2'b10
	} eiap_hstate_e;

	eiap_hstate_e  state;
	eiap_hstate_e  next_state;
	logic [PW-1:0] prog_cnt;
	logic [PW-1:0] next_prog_cnt;
	logic [GW-1:0] guard_cnt;
	logic [GW-1:0] next_guard_cnt;
	logic [UW-1:0] user_cnt;
	logic [UW-1:0] next_user_cnt;
	logic [7:0]    ptr_copy;
	logic [7:0]    next_ptr_copy;
	logic          pend_gc;
	logic          next_pend_gc;
	logic          req;
	logic          wr;
	logic          gcall;
	logic [7:0]    addr;
	logic [7:0]    wdata;
	logic          next_req;
	logic          next_wr;
	logic          next_gcall;
	logic [7:0]    next_addr;
	logic [7:0]    next_wdata;
	logic          next_rsp_valid;
	logic [7:0]    next_rsp_data;
	logic          is_gc;
	logic          is_data;
	logic          is_user_wr;
	logic          is_shutter_go;
	logic          blocked;
	logic          fire;

	// ------------------------------------------------------------
	// Admission of a command
	// ------------------------------------------------------------
	assign is_gc         = (cmd_kind == eiap_pkg::EIAP_K_GCALL);
	assign is_data       = !is_gc && (cmd_addr == eiap_pkg::REG_NV_DATA);
	assign is_user_wr    = is_data && (cmd_kind == eiap_pkg::EIAP_K_WRITE)
		&& (ptr_copy == eiap_pkg::REG_USER_NV);
	assign is_shutter_go = (cmd_kind == eiap_pkg::EIAP_K_WRITE)
		&& (cmd_addr == eiap_pkg::REG_SHUTTER) && cmd_data[eiap_pkg::SHUTTER_GO_BIT];
	assign user_limit_hit = (user_cnt >= UW'(USER_WRITE_LIMIT));
	assign blocked = (is_data && (prog_cnt != '0)) // RL16
		|| (is_user_wr && acq_active) // RL11
		|| (is_user_wr && user_limit_hit) // RL12
		|| (is_shutter_go && !seq_loaded) // RL15
		|| (!is_gc && !link.ready); // RL15
	assign cmd_ready = (state == H_IDLE) && (guard_cnt == '0) && !blocked; // RL13
	assign fire      = cmd_valid && cmd_ready;

	// ------------------------------------------------------------
	// Sequencing and timers
	// ------------------------------------------------------------
	always_comb
	begin
		next_state     = state;
		next_prog_cnt  = (prog_cnt != '0) ? prog_cnt - PW'(1) : prog_cnt;
		next_guard_cnt = (guard_cnt != '0) ? guard_cnt - GW'(1) : guard_cnt;
		next_user_cnt  = user_cnt;
		next_ptr_copy  = ptr_copy;
		next_pend_gc   = pend_gc;
		next_req       = 1'b0;
		next_wr        = wr;
		next_gcall     = gcall;
		next_addr      = addr;
		next_wdata     = wdata;
		next_rsp_valid = 1'b0;
		next_rsp_data  = rsp_data;
		unique case (state)
			H_IDLE:
			begin
				if (fire)
				begin
					next_state   = H_WAIT;
					next_req     = 1'b1;
					next_wr      = (cmd_kind != eiap_pkg::EIAP_K_READ);
					next_gcall   = is_gc;
					next_addr    = cmd_addr;
					next_wdata   = is_gc ? eiap_pkg::GCALL_RESET : cmd_data; // RL13
					next_pend_gc = is_gc;
					if (is_data && (cmd_kind == eiap_pkg::EIAP_K_WRITE))
						next_prog_cnt = PW'(PROG_CYCLES); // RL16
					if (is_user_wr)
						next_user_cnt = user_cnt + UW'(1); // RL12
					if (!is_gc && (cmd_kind == eiap_pkg::EIAP_K_WRITE)
						&& (cmd_addr == eiap_pkg::REG_NV_ADDR))
						next_ptr_copy = cmd_data; // RL1
					if (!is_gc && (cmd_kind == eiap_pkg::EIAP_K_READ) && is_data)
						next_ptr_copy = ptr_copy + 8'h01;
				end
			end
			H_WAIT:
			begin
				if (link.ack)
				begin
					next_state     = H_IDLE;
					next_rsp_valid = 1'b1;
					next_rsp_data  = link.rdata;
					if (pend_gc)
					begin
						next_guard_cnt = GW'(RESET_WAIT_CYCLES); // RL13
						next_ptr_copy  = eiap_pkg::NV_ADDR_RESET;
						next_prog_cnt  = '0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state     <= H_IDLE;
			prog_cnt  <= '0;
			guard_cnt <= '0;
			user_cnt  <= '0;
			ptr_copy  <= eiap_pkg::NV_ADDR_RESET;
			pend_gc   <= 1'b0;
			req       <= 1'b0;
			wr        <= 1'b0;
			gcall     <= 1'b0;
			addr      <= eiap_pkg::READ_ZERO;
			wdata     <= eiap_pkg::READ_ZERO;
			rsp_valid <= 1'b0;
			rsp_data  <= eiap_pkg::READ_ZERO;
		end
		else
		begin
			state     <= next_state;
			prog_cnt  <= next_prog_cnt;
			guard_cnt <= next_guard_cnt;
			user_cnt  <= next_user_cnt;
			ptr_copy  <= next_ptr_copy;
			pend_gc   <= next_pend_gc;
			req       <= next_req;
			wr        <= next_wr;
			gcall     <= next_gcall;
			addr      <= next_addr;
			wdata     <= next_wdata;
			rsp_valid <= next_rsp_valid;
			rsp_data  <= next_rsp_data;
		end
	end

	assign link.req   = req;
	assign link.wr    = wr;
	assign link.gcall = gcall;
	assign link.addr  = addr;
	assign link.wdata = wdata;

endmodule

// >>> core/eiap_if.sv
// Register access link between the host processor and the device
interface eiap_if;
	logic       req;
	logic       wr;
	logic       gcall;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       ack;
	logic [7:0] rdata;
	logic       ready;

	modport dev
	(
		input  req,
		input  wr,
		input  gcall,
		input  addr,
		input  wdata,
		output ack,
		output rdata,
		output ready
	);

	modport host
	(
		output req,
		output wr,
		output gcall,
		output addr,
		output wdata,
		input  ack,
		input  rdata,
		input  ready
	);
endinterface

// >>> core/eiap_pkg.sv
// Shared constants and types of the indirect nonvolatile access port
package eiap_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ            = 40_000_000;
	localparam int unsigned PROG_TIME_MS      = 20;
	localparam int unsigned PROG_CYCLES       = PROG_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned RESET_WAIT_NS     = 100;
	// Strictly longer than the wait, so one extra cycle
	localparam int unsigned RESET_WAIT_CYCLES = (RESET_WAIT_NS * (CLK_HZ / 1_000_000)) / 1000 + 1;
	localparam int unsigned USER_WRITE_LIMIT  = 100;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_SIL_REV   = 8'h01;
	localparam logic [7:0] REG_NV_ADDR   = 8'h11;
	localparam logic [7:0] REG_NV_DATA   = 8'h12;
	localparam logic [7:0] REG_SHUTTER   = 8'ha4;
	localparam logic [7:0] REG_USER_NV   = 8'hf0;
	localparam logic [7:0] REG_CUSTOMER  = 8'hf5;
	localparam logic [7:0] REG_WAFER_HI  = 8'hf6;
	localparam logic [7:0] REG_WAFER_LO  = 8'hf7;
	localparam logic [7:0] REG_DIE_HI    = 8'hf8;
	localparam logic [7:0] REG_DIE_LO    = 8'hf9;
	localparam logic [7:0] REG_PART_TYPE = 8'hfa;
	localparam logic [7:0] REG_PART_REL  = 8'hfb;

	// ------------------------------------------------------------
	// Fields, reset values, commands
	// ------------------------------------------------------------
	localparam int unsigned NV_DEPTH       = 16;
	localparam int unsigned NV_IDX_W       = 4;
	localparam logic [7:0]  NV_PAGE_BASE   = 8'hf0;
	localparam logic [7:0]  NV_ADDR_RESET  = 8'h00;
	localparam logic [7:0]  USER_NV_RESET  = 8'h00;
	localparam logic [7:0]  CUSTOMER_RESET = 8'h00;
	localparam logic [7:0]  READ_ZERO      = 8'h00;
	localparam logic [7:0]  GCALL_RESET    = 8'h06;
	localparam int unsigned SHUTTER_GO_BIT = 0;

	typedef enum logic [1:0] {
		EIAP_K_WRITE = 2'h0,
		EIAP_K_READ  = 2'h1,
		EIAP_K_GCALL = 2'h2
	} eiap_kind_e;

	// ------------------------------------------------------------
	// Address decoding
	// ------------------------------------------------------------
	function automatic logic nv_in_page(input logic [7:0] a);
		return a[7:NV_IDX_W] == NV_PAGE_BASE[7:NV_IDX_W];
	endfunction

	function automatic logic nv_writable(input logic [7:0] a);
		return a == REG_USER_NV;
	endfunction

endpackage

// >>> testbench/eiap_props.sv
// Link checker for the indirect nonvolatile access port
module eiap_props #(
	parameter int         PROG_CYCLES = 20,
	parameter logic [7:0] SILICON_REV = 8'h00
) (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       req,
	input wire logic       wr,
	input wire logic       gcall,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       ack,
	input wire logic [7:0] rdata,
	input wire logic       ready
);
	timeunit 1ns;
	timeprecision 100ps;

	localparam int PROG_LO = PROG_CYCLES;
	localparam int PROG_HI = PROG_CYCLES + 2;

	logic data_wr;
	logic dir_rd;

	assign data_wr = req && wr && !gcall && addr == 8'h12;
	assign dir_rd  = req && !wr && !gcall;

	default clocking dcb @(posedge clock);
	endclocking
	default disable iff (rst);

	ack_timing_a : assert property (req |=> ack)
		else $error("no answer one cycle after request");
	stray_ack_a : assert property (ack |-> $past(req))
		else $error("answer without request");
	one_outstanding_a : assert property (ack |-> !req)
		else $error("request while answer pending");
	idle_data_a : assert property (!ack |-> rdata == 8'h00)
		else $error("read data outside answer cycle");
	revision_read_a : assert property (dir_rd && addr == 8'h01 |=> rdata == SILICON_REV)
		else $error("silicon revision read wrong");
	id_hidden_a : assert property (dir_rd && addr inside {[8'hf6:8'hf9], 8'hfb}
		|=> rdata == 8'h00)
		else $error("identifier visible as live register");
	prog_busy_a : assert property (data_wr |-> ##2 !ready [*8])
		else $error("data write did not start programming");
	prog_time_a : assert property (data_wr |-> ##[PROG_LO:PROG_HI] $rose(ready))
		else $error("programming time wrong");
	gcall_reset_a : assert property (req && gcall |=> ack ##1 !ready ##1 ready)
		else $error("general call reset sequence wrong");
	ready_gate_a : assert property (req && !gcall |-> ready)
		else $error("request while device not ready");
endmodule

// >>> testbench/eiap_tb.sv
// Self-checking bench joining host and device ends
module eiap_tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int          PROG    = 20;
	localparam logic [7:0]  SIL_REV = 8'h5e;    // Value is arbitrary
	localparam logic [15:0] WAFER   = 16'h6b13; // Value is arbitrary
	localparam logic [15:0] DIE     = 16'h40c7; // Value is arbitrary
	localparam logic [7:0]  PTYPE   = 8'h3a;    // Value is arbitrary
	localparam logic [7:0]  PREL    = 8'h17;    // Value is arbitrary

	logic                 clock;
	logic                 rst;
	logic                 nv_init;
	logic                 cmd_valid;
	logic                 cmd_ready;
	eiap_pkg::eiap_kind_e cmd_kind;
	logic [7:0]           cmd_addr;
	logic [7:0]           cmd_data;
	logic                 acq_active;
	logic                 seq_loaded;
	logic                 rsp_valid;
	logic [7:0]           rsp_data;
	logic                 user_limit_hit;
	logic [7:0]           ids [0:6];
	logic [7:0]           hid [0:4];
	int                   fails;
	int                   checked;

	eiap_if link ();

	eiap_device #(.PROG_CYCLES(PROG), .SILICON_REV(SIL_REV), .WAFER_IDENT(WAFER), .DIE_ID(DIE),
		.PART_TYPE(PTYPE), .PART_REL(PREL)) i_eiap_device (.clock(clock), .rst(rst),
		.nv_init(nv_init), .link(link.dev));

	eiap_host #(.PROG_CYCLES(PROG), .USER_WRITE_LIMIT(2)) i_eiap_host (.clock(clock),
		.rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .acq_active(acq_active),
		.seq_loaded(seq_loaded), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.user_limit_hit(user_limit_hit), .link(link.host));

	eiap_props #(.PROG_CYCLES(PROG), .SILICON_REV(SIL_REV)) i_eiap_props (.clock(clock),
		.rst(rst), .req(link.req), .wr(link.wr), .gcall(link.gcall), .addr(link.addr),
		.wdata(link.wdata), .ack(link.ack), .rdata(link.rdata), .ready(link.ready));

	initial
	begin
		clock = 1'b0;
	end
	always #12.5 clock = ~clock;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic access(input eiap_pkg::eiap_kind_e k, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] rd);
		int n;
		@(negedge clock);
		cmd_kind = k;
		cmd_addr = a;
		cmd_data = d;
		cmd_valid = 1'b1;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 200)
		begin
			@(negedge clock);
			n++;
		end
		check({7'h00, cmd_ready}, 8'h01, "command accepted");
		@(negedge clock);
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 10)
		begin
			@(negedge clock);
			n++;
		end
		check({7'h00, rsp_valid}, 8'h01, "response arrived");
		rd = rsp_data;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] rd;
		access(eiap_pkg::EIAP_K_WRITE, a, d, rd);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] rd;
		access(eiap_pkg::EIAP_K_READ, a, 8'h00, rd);
		check(rd, exp, what);
	endtask

	// Programming window passes first, so only the intended cause can refuse
	task automatic refuse(input logic [7:0] a, input logic [7:0] d, input string what);
		repeat (PROG + 5) @(negedge clock);
		cmd_kind = eiap_pkg::EIAP_K_WRITE;
		cmd_addr = a;
		cmd_data = d;
		cmd_valid = 1'b1;
		repeat (4)
		begin
			@(negedge clock);
			check({7'h00, cmd_ready}, 8'h00, what);
		end
		cmd_valid = 1'b0;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		logic [7:0] d;
		rst = 1'b1;
		nv_init = 1'b1;
		cmd_valid = 1'b0;
		cmd_kind = eiap_pkg::EIAP_K_WRITE;
		cmd_addr = 8'h00;
		cmd_data = 8'h00;
		acq_active = 1'b0;
		seq_loaded = 1'b0;
		fails = 0;
		checked = 0;
		ids = '{eiap_pkg::CUSTOMER_RESET, WAFER[15:8], WAFER[7:0], DIE[15:8], DIE[7:0],
			PTYPE, PREL};
		hid = '{8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfb};
		@(negedge clock);
		nv_init = 1'b0;
		@(negedge clock);
		rst = 1'b0;

		rdchk(8'h01, SIL_REV, "silicon revision");
		wr(8'h11, 8'hf5);
		rdchk(8'h11, 8'hf5, "address register");
		for (int i = 0; i < 7; i++)
			rdchk(8'h12, ids[i], "identification byte");
		for (int i = 0; i < 5; i++)
			rdchk(hid[i], eiap_pkg::READ_ZERO, "direct identifier read");
		rdchk(8'h7e, eiap_pkg::READ_ZERO, "unmapped read");
		$display("test identification done");

		wr(8'h11, 8'hf0);
		wr(8'h12, 8'h22);
		rdchk(8'hf0, eiap_pkg::USER_NV_RESET, "live user byte");
		wr(8'h11, 8'hf0);
		rdchk(8'h12, 8'h22, "stored user byte");
		rdchk(8'hf0, eiap_pkg::USER_NV_RESET, "live byte after read");
		wr(8'h11, 8'hf0);
		acq_active = 1'b1;
		refuse(8'h12, 8'h33, "user write in acquisition");
		acq_active = 1'b0;
		wr(8'h12, 8'h35);
		check({7'h00, user_limit_hit}, 8'h01, "write limit flag");
		refuse(8'h12, 8'h44, "user write beyond limit");
		$display("test user byte done");

		refuse(8'ha4, 8'h01, "shutter before program");
		seq_loaded = 1'b1;
		wr(8'ha4, 8'h01);
		$display("test shutter order done");

		access(eiap_pkg::EIAP_K_GCALL, 8'h00, eiap_pkg::GCALL_RESET, d);
		check(d, eiap_pkg::READ_ZERO, "general call answer");
		rdchk(8'hf0, 8'h35, "user byte copied at reset");
		rdchk(8'hf5, eiap_pkg::CUSTOMER_RESET, "live customer byte");
		rdchk(8'hfa, PTYPE, "live part type");
		rdchk(8'h12, eiap_pkg::READ_ZERO, "pointer cleared by reset");
		wr(8'h11, 8'hf6);
		wr(8'h12, 8'h99);
		wr(8'h11, 8'hf6);
		rdchk(8'h12, WAFER[15:8], "read-only byte kept");
		wr(8'hf0, 8'h6c);
		rdchk(8'hf0, 8'h6c, "direct live write");
		wr(8'h11, 8'hf0);
		rdchk(8'h12, 8'h35, "array kept on direct write");
		$display("test reset and read-only done");
		stop_test();
	end

	initial
	begin
		#(25 * 6000);
		fails++;
		$display("MISMATCH at %0t: run timed out", $time);
		stop_test();
	end
endmodule
